//--- shared/dpram_pkg.sv
// constants shared by the dual-port memory and its port front end
package dpram_pkg;
   // ***************************************************************
   // geometry
   // ***************************************************************
   localparam int ADDR_W = 13;          // 13 gives 8K words, 12 gives 4K
   localparam int DATA_W = 18;
   localparam int HALF_W = 9;
   localparam int UPPER  = 1;           // index of upper half in masks
   localparam int LOWER  = 0;           // index of lower half in masks
   // ***************************************************************
   // mode select levels and reset values
   // ***************************************************************
   localparam logic MODE_FLOW = 1'h0;
   localparam logic MODE_PIPE = 1'h1;
   localparam logic [1:0]        OE_RST   = 2'h0;
   localparam logic [DATA_W-1:0] DATA_RST = 18'h00000;
endpackage

//--- verilog/port_front.sv
// one port: address counter, byte-select decode and read output path
`timescale 1ns/1ns
`default_nettype none
module port_front #(
   parameter int ADDR_W = dpram_pkg::ADDR_W
) (
   input  wire logic                        clk,
   input  wire logic                        rst,
   input  wire logic [ADDR_W-1:0]           addr,
   input  wire logic                        addr_strobe_n,
   input  wire logic                        burst_advance_n,
   input  wire logic                        burst_clear_n,
   input  wire logic                        chip_sel_active_low,
   input  wire logic                        chip_sel_active_high,
   input  wire logic                        write_n,
   input  wire logic                        upper_byte_sel_n,
   input  wire logic                        lower_byte_sel_n,
   input  wire logic                        output_enable_n,
   input  wire logic                        output_mode_sel,
   input  wire logic [dpram_pkg::DATA_W-1:0] array_rd,
   output logic      [ADDR_W-1:0]           access_addr,
   output logic                             wr_en,
   output logic      [1:0]                  wr_half,
   output logic      [dpram_pkg::DATA_W-1:0] data_out,
   output logic      [1:0]                  data_oe,
   output logic                             powered_down
);
   // ***************************************************************
   // state
   // ***************************************************************
   logic [ADDR_W-1:0]            cnt_ff, nxt_cnt;
   logic [dpram_pkg::DATA_W-1:0] pipe_ff, nxt_pipe;
   logic [1:0]                   pipe_oe_ff, nxt_pipe_oe;
   logic [dpram_pkg::DATA_W-1:0] out_ff, nxt_out;
   logic [1:0]                   oe_ff, nxt_oe;
   logic                         pd_ff, nxt_pd;
   logic                         selected;
   logic                         rd_now;
   logic [1:0]                   half_en;

   // ***************************************************************
   // next-state logic
   // ***************************************************************
   // counter doubles as the input address register
   always_comb begin
      selected = !chip_sel_active_low && chip_sel_active_high;
      half_en  = {!upper_byte_sel_n, !lower_byte_sel_n};
      if (!burst_clear_n) begin
         nxt_cnt = '0;                  // clear beats strobe and advance
      end else if (!addr_strobe_n) begin
         nxt_cnt = addr;
      end else if (!burst_advance_n) begin
         nxt_cnt = cnt_ff + 1'h1;       // wraps to zero
      end else begin
         nxt_cnt = cnt_ff;
      end
      // every access uses the next counter value, so a burst walks words
      access_addr = nxt_cnt;
      // low write select writes, high reads
      wr_en   = selected && !write_n;
      wr_half = half_en & {2{wr_en}};
      rd_now  = selected && write_n;
      nxt_pd  = !selected;
      // pipeline stage always loads; used only in pipelined mode
      nxt_pipe    = array_rd;
      nxt_pipe_oe = half_en & {2{rd_now}};
      if (output_mode_sel == dpram_pkg::MODE_PIPE) begin
         // deselect drains through the stage: one active cycle needed
         nxt_out = pipe_ff;
         nxt_oe  = pipe_oe_ff & {2{!output_enable_n}};
      end else begin
         nxt_out = array_rd;            // bypass the stage
         nxt_oe  = nxt_pipe_oe & {2{!output_enable_n}};
      end
   end

   // ***************************************************************
   // registers
   // ***************************************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_ff     <= '0;
         pipe_ff    <= dpram_pkg::DATA_RST;
         pipe_oe_ff <= dpram_pkg::OE_RST;
         out_ff     <= dpram_pkg::DATA_RST;
         oe_ff      <= dpram_pkg::OE_RST;
         pd_ff      <= 1'h1;
      end else begin
         cnt_ff     <= nxt_cnt;
         pipe_ff    <= nxt_pipe;
         pipe_oe_ff <= nxt_pipe_oe;
         out_ff     <= nxt_out;
         oe_ff      <= nxt_oe;
         pd_ff      <= nxt_pd;
      end
   end

   assign data_out     = out_ff;
   assign data_oe      = oe_ff;
   assign powered_down = pd_ff;
endmodule
`default_nettype wire

//--- verilog/dual_port_ram.sv
// dual-port static memory array with two independent port front ends
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - two ports access any word each cycle
// - pipelined mode passes data through output stage
// - flow-through mode bypasses the output stage
// - static select input picks output mode
// - inactive chip enable deselects, powers down port
// - pipelined: one active cycle before outputs return
// - each port owns its burst counter
// - address strobe loads the counter
// - counter enable uses internal address instead
// - counter advances one per clock edge
// - burst moves one word per clock
// - counter wraps from last word to zero
// - clear returns counter to zero
// - write strobe is internal, self timed
// - separate upper and lower half selects
// - low selects flow-through, high pipelined
// - advance ignored during strobe or clear
// - clear wins over strobe and advance
// - low write select writes, high reads
module dual_port_ram #(
   parameter int ADDR_W = dpram_pkg::ADDR_W
) (
   input  wire logic                         clk,
   input  wire logic                         rst,
   input  wire logic [ADDR_W-1:0]            left_addr,
   input  wire logic                         left_addr_strobe_n,
   input  wire logic                         left_burst_advance_n,
   input  wire logic                         left_burst_clear_n,
   input  wire logic                         left_chip_sel_active_low,
   input  wire logic                         left_chip_sel_active_high,
   input  wire logic                         left_write_n,
   input  wire logic                         left_upper_byte_sel_n,
   input  wire logic                         left_lower_byte_sel_n,
   input  wire logic                         left_output_enable_n,
   input  wire logic                         left_output_mode_sel,
   input  wire logic [dpram_pkg::DATA_W-1:0] left_data_in,
   output logic      [dpram_pkg::DATA_W-1:0] left_data_out,
   output logic      [1:0]                   left_data_oe,
   output logic                              left_powered_down,
   input  wire logic [ADDR_W-1:0]            right_addr,
   input  wire logic                         right_addr_strobe_n,
   input  wire logic                         right_burst_advance_n,
   input  wire logic                         right_burst_clear_n,
   input  wire logic                         right_chip_sel_active_low,
   input  wire logic                         right_chip_sel_active_high,
   input  wire logic                         right_write_n,
   input  wire logic                         right_upper_byte_sel_n,
   input  wire logic                         right_lower_byte_sel_n,
   input  wire logic                         right_output_enable_n,
   input  wire logic                         right_output_mode_sel,
   input  wire logic [dpram_pkg::DATA_W-1:0] right_data_in,
   output logic      [dpram_pkg::DATA_W-1:0] right_data_out,
   output logic      [1:0]                   right_data_oe,
   output logic                              right_powered_down
);
   localparam int DEPTH = 1 << ADDR_W;
   localparam int HW    = dpram_pkg::HALF_W;

   // ***************************************************************
   // array and port wiring
   // ***************************************************************
   logic [dpram_pkg::DATA_W-1:0] mem [DEPTH];
   logic [ADDR_W-1:0]            left_acc, right_acc;
   logic                         left_wr, right_wr;
   logic [1:0]                   left_half, right_half;
   logic [dpram_pkg::DATA_W-1:0] left_rd, right_rd;

   // read-before-write: a word read while written shows old contents
   always_comb begin
      left_rd  = mem[left_acc];
      right_rd = mem[right_acc];
   end

   // ***************************************************************
   // port front ends
   // ***************************************************************
   port_front #(.ADDR_W(ADDR_W)) u_left (
      .clk                  (clk),
      .rst                  (rst),
      .addr                 (left_addr),
      .addr_strobe_n        (left_addr_strobe_n),
      .burst_advance_n      (left_burst_advance_n),
      .burst_clear_n        (left_burst_clear_n),
      .chip_sel_active_low  (left_chip_sel_active_low),
      .chip_sel_active_high (left_chip_sel_active_high),
      .write_n              (left_write_n),
      .upper_byte_sel_n     (left_upper_byte_sel_n),
      .lower_byte_sel_n     (left_lower_byte_sel_n),
      .output_enable_n      (left_output_enable_n),
      .output_mode_sel      (left_output_mode_sel),
      .array_rd             (left_rd),
      .access_addr          (left_acc),
      .wr_en                (left_wr),
      .wr_half              (left_half),
      .data_out             (left_data_out),
      .data_oe              (left_data_oe),
      .powered_down         (left_powered_down)
   );

   port_front #(.ADDR_W(ADDR_W)) u_right (
      .clk                  (clk),
      .rst                  (rst),
      .addr                 (right_addr),
      .addr_strobe_n        (right_addr_strobe_n),
      .burst_advance_n      (right_burst_advance_n),
      .burst_clear_n        (right_burst_clear_n),
      .chip_sel_active_low  (right_chip_sel_active_low),
      .chip_sel_active_high (right_chip_sel_active_high),
      .write_n              (right_write_n),
      .upper_byte_sel_n     (right_upper_byte_sel_n),
      .lower_byte_sel_n     (right_lower_byte_sel_n),
      .output_enable_n      (right_output_enable_n),
      .output_mode_sel      (right_output_mode_sel),
      .array_rd             (right_rd),
      .access_addr          (right_acc),
      .wr_en                (right_wr),
      .wr_half              (right_half),
      .data_out             (right_data_out),
      .data_oe              (right_data_oe),
      .powered_down         (right_powered_down)
   );

   // ***************************************************************
   // array write
   // ***************************************************************
   // one edge is the whole write strobe, no pulse shaping needed;
   // on a same-word collision right lands last, which callers must
   // not rely on
   always_ff @(posedge clk) begin
      if (left_wr && left_half[dpram_pkg::UPPER]) begin
         mem[left_acc][2*HW-1:HW] <= left_data_in[2*HW-1:HW];
      end
      if (left_wr && left_half[dpram_pkg::LOWER]) begin
         mem[left_acc][HW-1:0] <= left_data_in[HW-1:0];
      end
      if (right_wr && right_half[dpram_pkg::UPPER]) begin
         mem[right_acc][2*HW-1:HW] <= right_data_in[2*HW-1:HW];
      end
      if (right_wr && right_half[dpram_pkg::LOWER]) begin
         mem[right_acc][HW-1:0] <= right_data_in[HW-1:0];
      end
   end
endmodule
`default_nettype wire

//--- verif/dpram_properties.sv
// concurrent checks on the left port of the dual-port memory
`timescale 1ns/1ns
`default_nettype none
module dpram_checker (
   input wire logic       clk,
   input wire logic       rst,
   input wire logic       left_chip_sel_active_low,
   input wire logic       left_chip_sel_active_high,
   input wire logic       left_write_n,
   input wire logic       left_upper_byte_sel_n,
   input wire logic       left_lower_byte_sel_n,
   input wire logic       left_output_enable_n,
   input wire logic       left_output_mode_sel,
   input wire logic [1:0] left_data_oe,
   input wire logic       left_powered_down
);
   // ******************************
   // left port output timing
   // ******************************
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // both enables must agree before the port counts as selected
   wire logic sel = !left_chip_sel_active_low && left_chip_sel_active_high;
   wire logic md  = left_output_mode_sel;
   a_desel_power_down:
   assert property (!sel |=> left_powered_down) else $error("no power-down");
   a_sel_power_up:
   assert property (sel |=> !left_powered_down) else $error("still down");
   a_flow_write_quiet:
   assert property (!md && !left_write_n |=> left_data_oe == 2'h0)
      else $error("write drove bus");
   a_flow_read_halves:
   assert property (!md && sel && left_write_n && !left_output_enable_n
      |=> left_data_oe == {!$past(left_upper_byte_sel_n),
                           !$past(left_lower_byte_sel_n)})
      else $error("flow read halves wrong");
   a_oe_gates_bus:
   assert property (left_output_enable_n |=> left_data_oe == 2'h0)
      else $error("drove with oe off");
   a_pipe_read_late:
   assert property (md && sel && left_write_n && !left_upper_byte_sel_n
      && !left_lower_byte_sel_n ##1 md && !left_output_enable_n
      |=> left_data_oe == 2'h3) else $error("pipe read missing");
   a_pipe_reactivate:
   assert property (md && !sel ##1 md |=> left_data_oe == 2'h0)
      else $error("pipe outputs back early");
   a_pipe_write_quiet:
   assert property (md && !left_write_n ##1 md |=> left_data_oe == 2'h0)
      else $error("pipe write drove bus");
   c_flow_read: cover property (!md && sel && left_write_n);
   c_pipe_read: cover property (md && sel && left_write_n ##1 md);
   c_deselect: cover property (md && !sel);
endmodule
bind dual_port_ram dpram_checker chk_u (.clk, .rst, .left_chip_sel_active_low,
   .left_chip_sel_active_high, .left_write_n, .left_upper_byte_sel_n,
   .left_lower_byte_sel_n, .left_output_enable_n, .left_output_mode_sel,
   .left_data_oe, .left_powered_down);
`default_nettype wire

//--- verif/right_host.sv
// far-side host on the right port: one four-word write burst
`timescale 1ns/1ns
`default_nettype none
module right_host (
   input  wire logic   clk,
   input  wire logic   go,
   output logic [12:0] right_addr,
   output logic        right_addr_strobe_n,
   output logic        right_burst_advance_n,
   output logic        right_write_n,
   output logic        right_chip_sel_active_low,
   output logic        right_chip_sel_active_high,
   output logic [17:0] right_data_in
);
   // ******************************
   // burst writer
   // ******************************
   // released address and data lines show the inverse of the last value, never a stale copy
   initial begin
      {right_addr_strobe_n, right_burst_advance_n, right_write_n} = 3'h7;
      {right_chip_sel_active_low, right_chip_sel_active_high} = 2'h2;
      right_addr = 13'h1fff;
      right_data_in = 18'h0;
      wait (go);
      @(negedge clk);
      for (int i = 0; i < 4; i++) begin
         {right_chip_sel_active_low, right_chip_sel_active_high} = 2'h1;
         right_write_n = 1'h0;
         right_addr_strobe_n = (i != 0);
         right_burst_advance_n = (i == 0);
         right_addr = (i == 0) ? 13'h100 : ~right_addr;
         right_data_in = 18'h2aa00 + 18'(i); // own words only
         @(negedge clk);
      end
      {right_chip_sel_active_low, right_chip_sel_active_high} = 2'h2;
      {right_addr_strobe_n, right_burst_advance_n, right_write_n} = 3'h7;
      right_addr = ~right_addr;
      right_data_in = ~right_data_in;
   end
endmodule
`default_nettype wire

//--- verif/tb.sv
// self-checking bench for the dual-port memory
`timescale 1ns/1ns
`default_nettype none
module tb;
   // ******************************
   // stimulus, design and checks
   // ******************************
   // control order: clear, strobe, advance, write, upper, lower
   localparam logic [5:0] LD_RD = 6'h2c, ADV_RD = 6'h34, HOLD_RD = 6'h3c;
   localparam logic [5:0] LD_WR = 6'h28, ADV_WR = 6'h30;
   localparam logic [17:0] W0 = 18'h11111, W1 = 18'h22222, W2 = 18'h33333;
   localparam logic [17:0] W0H = {W0[17:9], 9'h1ff}, P0 = 18'h2aa00;
   logic clk = 1'h0, rst = 1'h1, go = 1'h0;
   logic left_addr_strobe_n = 1'h1, left_burst_advance_n = 1'h1;
   logic left_burst_clear_n = 1'h1, left_write_n = 1'h1;
   logic left_upper_byte_sel_n = 1'h0, left_lower_byte_sel_n = 1'h0;
   logic left_chip_sel_active_low = 1'h0, left_chip_sel_active_high = 1'h1;
   logic left_output_enable_n = 1'h0, left_output_mode_sel = 1'h0;
   logic [12:0] left_addr = 13'h0, right_addr;
   logic [17:0] left_data_in = 18'h0, left_data_out, right_data_in;
   logic [1:0]  left_data_oe, right_data_oe;
   logic [17:0] right_data_out;
   logic left_powered_down, right_powered_down, right_addr_strobe_n;
   logic right_burst_advance_n, right_write_n;
   logic right_chip_sel_active_low, right_chip_sel_active_high;
   int bad_count = 0, compares = 0;
   always #25 clk = ~clk;
   dual_port_ram dut_u (.clk, .rst, .left_addr, .left_addr_strobe_n,
      .left_burst_advance_n, .left_burst_clear_n, .left_chip_sel_active_low,
      .left_chip_sel_active_high, .left_write_n, .left_upper_byte_sel_n,
      .left_lower_byte_sel_n, .left_output_enable_n, .left_output_mode_sel,
      .left_data_in, .left_data_out, .left_data_oe, .left_powered_down,
      .right_addr, .right_addr_strobe_n, .right_burst_advance_n,
      .right_burst_clear_n(1'h1), .right_chip_sel_active_low,
      .right_chip_sel_active_high, .right_write_n,
      .right_upper_byte_sel_n(1'h0), .right_lower_byte_sel_n(1'h0),
      .right_output_enable_n(1'h0), .right_output_mode_sel(1'h0),
      .right_data_in, .right_data_out, .right_data_oe,
      .right_powered_down);
   right_host host_u (.clk, .go, .right_addr, .right_addr_strobe_n,
      .right_burst_advance_n, .right_write_n, .right_chip_sel_active_low,
      .right_chip_sel_active_high, .right_data_in);
   task automatic chk(input logic [17:0] seen, input logic [17:0] want);
      compares++;
      if (seen !== want) begin
         bad_count++;
         $display("BAD %0t seen %h want %h", $time, seen, want);
      end
   endtask
   // inputs change at the falling edge; outputs settled at the next one
   task automatic drv(input logic [5:0] c, input logic [12:0] a,
                      input logic [17:0] d);
      {left_burst_clear_n, left_addr_strobe_n, left_burst_advance_n,
       left_write_n, left_upper_byte_sel_n, left_lower_byte_sel_n} = c;
      left_addr = a;
      left_data_in = d;
      @(negedge clk);
   endtask
   task automatic end_of_test;
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // burst writes across the top word so the counter must wrap
   task automatic t_write;
      drv(LD_WR, 13'h1ffe, W0);
      chk({16'h0, left_data_oe}, 18'h0);
      drv(ADV_WR, 13'h0, W1);
      drv(ADV_WR, 13'h0, W2);
   endtask
   task automatic t_read;
      drv(LD_RD, 13'h1ffe, 18'h0);
      chk(left_data_out, W0);
      chk({16'h0, left_data_oe}, 18'h3);
      drv(ADV_RD, 13'h0, 18'h0);
      chk(left_data_out, W1);
      drv(ADV_RD, 13'h0, 18'h0);
      chk(left_data_out, W2);
   endtask
   task automatic t_counter;
      drv(6'h04, 13'h1fff, 18'h0);
      chk(left_data_out, W2);
      drv(6'h24, 13'h1ffe, 18'h0);
      chk(left_data_out, W0);
      drv(ADV_RD, 13'h0, 18'h0);
      chk(left_data_out, W1);
      left_output_enable_n = 1'h1;
      drv(HOLD_RD, 13'h0, 18'h0);
      chk({16'h0, left_data_oe}, 18'h0);
      left_output_enable_n = 1'h0;
   endtask
   task automatic t_halves;
      drv(6'h2a, 13'h1ffe, 18'h3ffff);
      drv(6'h3e, 13'h0, 18'h0);
      chk({16'h0, left_data_oe}, 18'h1);
      drv(HOLD_RD, 13'h0, 18'h0);
      chk(left_data_out, W0H);
   endtask
   task automatic t_pipe;
      left_output_mode_sel = 1'h1;
      drv(LD_RD, 13'h1fff, 18'h0);
      drv(ADV_RD, 13'h0, 18'h0);
      chk(left_data_out, W1);
      drv(HOLD_RD, 13'h0, 18'h0);
      chk(left_data_out, W2);
      left_chip_sel_active_high = 1'h0;
      drv(HOLD_RD, 13'h0, 18'h0);
      chk({17'h0, left_powered_down}, 18'h1);
      left_chip_sel_active_high = 1'h1;
      drv(LD_RD, 13'h1ffe, 18'h0);
      chk({16'h0, left_data_oe}, 18'h0);
      drv(LD_WR, 13'h1ffe, W0H);
      chk(left_data_out, W0H);
      drv(HOLD_RD, 13'h0, 18'h0);
      chk({16'h0, left_data_oe}, 18'h0);
      left_output_mode_sel = 1'h0;
   endtask
   // far port writes while this port reads elsewhere on the same edge
   task automatic t_both;
      go = 1'h1;
      drv(HOLD_RD, 13'h0, 18'h0);
      drv(LD_RD, 13'h1fff, 18'h0);
      chk(left_data_out, W1);
      repeat (5) drv(HOLD_RD, 13'h0, 18'h0);
      chk({17'h0, right_powered_down}, 18'h1);
      drv(LD_RD, 13'h100, 18'h0);
      chk(left_data_out, P0);
      for (int i = 1; i < 4; i++) begin
         drv(ADV_RD, 13'h0, 18'h0);
         chk(left_data_out, P0 + 18'(i));
      end
      // far counter holds its last burst word; deselected, so no drive
      chk(right_data_out, P0 + 18'h3);
      chk({16'h0, right_data_oe}, 18'h0);
   endtask
   initial begin
      repeat (2) @(negedge clk);
      rst = 1'h0;
      @(negedge clk);
      t_write();
      t_read();
      t_counter();
      t_halves();
      t_pipe();
      t_both();
      end_of_test();
   end
   // about 34 cycles are needed; over ten times that means a hang
   initial begin
      #(400 * 50);
      bad_count++;
      end_of_test();
   end
endmodule
`default_nettype wire
